// File: design/cvh_buf2.v
// Two-entry valid/ready buffer for one data byte stream.
`timescale 1ns/1ns
`default_nettype none
module cvh_buf2
(
   input  wire       core_clk,  // System clock.
   input  wire       resetn,    // Asynchronous reset, active low.
   input  wire       flush,     // Empties both entries.
   input  wire       inValid,   // Source offers a byte.
   output wire       inReady,   // Buffer can take a byte.
   input  wire [7:0] inData,    // Byte offered.
   output wire       outValid,  // Buffer holds a byte.
   input  wire       outReady,  // Sink takes the head byte.
   output wire [7:0] outData    // Head byte, from a flip-flop.
);
   reg [7:0] ent0_reg;          // Head entry.
   reg [7:0] ent1_reg;          // Second entry.
   reg [1:0] cnt_reg;           // Number of entries held.
   wire      push;              // Write accepted.
   wire      pop;               // Read accepted.

   assign inReady  = (cnt_reg != 2'h2);
   assign outValid = (cnt_reg != 2'h0);
   assign outData  = ent0_reg;
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // Storage moves the second entry forward on a pop, so the head stays
   // registered and no read mux sits in the output path.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ent0_reg <= 8'h00;
         ent1_reg <= 8'h00;
         cnt_reg  <= 2'h0;
      end
      else if (flush)
      begin
         cnt_reg <= 2'h0;
      end
      else
      begin
         if (pop)
         begin
            // Shift forward, or load directly when only one was held.
            if (cnt_reg == 2'h2)
               ent0_reg <= ent1_reg;
            else if (push)
               ent0_reg <= inData;
            if (push && cnt_reg == 2'h2)
               ent1_reg <= inData;
            else if (push)
               ent1_reg <= inData;
         end
         else if (push)
         begin
            // Fill the first free slot.
            if (cnt_reg == 2'h0)
               ent0_reg <= inData;
            else
               ent1_reg <= inData;
         end
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule
`default_nettype wire

// File: design/cvh_host_port.v
// Host port registers, status flags and interrupt logic of the voice codec.
//
// Functional notes
// - Word B bit4 set routes input A directly.
// - Word B bit5 set routes decoder to B.
// - Word B bit6 set enters power-save mode.
// - Word B bit7 selects high power sensitivity.
// - Encode-ready sets on last bit, requests interrupt.
// - Encode-ready clears on read or overspill.
// - Decode-ready sets when decode register loads.
// - Decode-ready clears on write or overspill.
// - Page-ready sets at page completion after levels.
// - Page-ready clears on level read or overspill.
// - Encode overspill on missed read; freezes buffer.
// - Encode overspill clears by read, or write if both overspilled.
// - Decode overspill blocks loads; idle unless loopback.
// - Decode overspill clears by write, or read if both overspilled.
// - Page overspill on missed read; clear by level read or word B write.
// - Level word: A/B low nibble, C high.
// - Interrupt on any of three ready flags.
// - Unserviced condition becomes overspill, inhibits requests; a page completion in page overspill still sets page-ready for one cycle.
// - Level word refreshes every page regardless.
// - Double overspill access resets both buffer paths.
// - Address lines and direction select the register.
// - Word A bit1 loops encoder into decoder.
// - Request output active low, open drain.
`timescale 1ns/1ns
`default_nettype none
`include "cvh_map.vh"
module cvh_host_port
(
   input  wire       core_clk,    // System clock, 125 MHz.
   input  wire       resetn,      // Asynchronous reset, active low.
   input  wire       csN,         // Chip select pin, active low.
   input  wire       addr0,       // Address line 0 pin.
   input  wire       addr1,       // Address line 1 pin.
   input  wire       readNotWrite,// Direction pin, high reads.
   input  wire [7:0] dataIn,      // Data port input side.
   output reg  [7:0] dataOut,     // Data port output side.
   output wire       dataOe,      // Data port drive enable.
   input  wire       encByteDone, // Encoder finished last bit of a byte.
   input  wire [7:0] encByte,     // Byte from the encode register.
   input  wire       decByteDone, // Decoder shifted out a byte's last bit.
   output reg  [7:0] decByte,     // Byte loaded into the decode register.
   output reg        decLoad,     // Decode register load strobe.
   input  wire       pageByte,    // Page counter counted one byte.
   input  wire [3:0] levelAB,     // Average level of input A/B.
   input  wire [3:0] levelC,      // Average level of input C.
   output wire       outADirect,  // Output A from input A directly.
   output wire       outBDecoder, // Output B from the decoder.
   output wire       powerSave,   // Analogue elements disabled.
   output wire       highSense,   // High-sensitivity power range.
   output wire       encIdle,     // Encoder forced to idle pattern.
   output wire       loopBack,    // Encoder output feeds decoder.
   output wire       irqNOut,     // Request pin level, always low.
   output wire       irqNOe       // Request pin drive enable.
);
   // Two-stage synchronisers for every pin input.
   reg  [11:0] pinS1_reg;         // First stage, read only by stage two.
   reg  [11:0] pinS2_reg;         // Second stage, read by logic.
   reg         csPrev_reg;        // Delayed select for edge detection.
   reg  [7:0]  wordA_reg;         // Instruction word A.
   reg  [7:0]  wordB_reg;         // Instruction word B.
   reg  [7:0]  level_reg;         // Level word.
   reg  [5:0]  flag_reg;          // Ready and overspill flags.
   reg  [8:0]  pageCnt_reg;       // Bytes counted in current page.
   wire        csS;               // Synchronised select, active high.
   wire [1:0]  sel;               // Synchronised address.
   wire        rdS;               // Synchronised direction.
   wire [7:0]  dinS;              // Synchronised data.
   wire        accStart;          // First cycle of an access.
   wire        wrA;               // Write instruction word A.
   wire        wrB;               // Write instruction word B.
   wire        wrDec;             // Write decode buffer.
   wire        rdFlag;            // Read flag word.
   wire        rdLevel;           // Read level word.
   wire        rdEnc;             // Read encode buffer.
   wire        bothOvr;           // Both data paths overspilled.
   wire        pathReset;         // Clear both buffer paths.
   wire        pageDone;          // Last byte of page counted.
   wire [8:0]  pageLen;           // Page length in bytes.
   wire        encInReady;        // Encode buffer has room.
   wire        encValid;          // Encode buffer holds a byte.
   wire [7:0]  encHead;           // Encode buffer head byte.
   wire        encArrive;         // Encoded byte offered, path not frozen.
   wire        encMiss;           // Byte arrives while the last is unread.
   wire        encPush;           // Move encoded byte into the buffer.
   wire        decValid;          // Decode buffer holds a byte.
   wire [7:0]  decHead;           // Decode buffer head byte.
   wire        decPop;            // Decode register takes a byte.
   wire        decRefill;         // Decode register reloads.

   // Pins cross into the clock domain through two flip-flops.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pinS1_reg  <= 12'h000;
         pinS2_reg  <= 12'h000;
         csPrev_reg <= 1'b0;
      end
      else
      begin
         pinS1_reg  <= {~csN, addr1, addr0, readNotWrite, dataIn};
         pinS2_reg  <= pinS1_reg;
         csPrev_reg <= pinS2_reg[11];
      end
   end

   assign csS  = pinS2_reg[11];
   assign sel  = pinS2_reg[10:9];
   assign rdS  = pinS2_reg[8];
   assign dinS = pinS2_reg[7:0];
   // One access acts once, on the rising select; a long select is harmless.
   assign accStart = csS & ~csPrev_reg;

   assign wrA     = accStart & ~rdS & (sel == `CVH_SEL_A);
   assign wrB     = accStart & ~rdS & (sel == `CVH_SEL_B);
   assign wrDec   = accStart & ~rdS & (sel == `CVH_SEL_DATA);
   assign rdFlag  = accStart &  rdS & (sel == `CVH_SEL_A);
   assign rdLevel = accStart &  rdS & (sel == `CVH_SEL_B);
   assign rdEnc   = accStart &  rdS & (sel == `CVH_SEL_DATA);
   // Driving only while a read is selected keeps the shared bus free.
   assign dataOe  = csS & rdS & (sel != 2'h3);

   // Instruction words hold their value until rewritten.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wordA_reg <= `CVH_WORD_RST;
         wordB_reg <= `CVH_WORD_RST;
      end
      else
      begin
         if (wrA)
            wordA_reg <= dinS;
         if (wrB)
            wordB_reg <= dinS;
      end
   end

   assign outADirect  = wordB_reg[`CVH_B_OUTA];
   assign outBDecoder = wordB_reg[`CVH_B_OUTB];
   assign powerSave   = wordB_reg[`CVH_B_PSAVE];
   assign highSense   = wordB_reg[`CVH_B_SENS];
   assign encIdle     = wordA_reg[`CVH_A_IDLE];
   assign loopBack    = wordA_reg[`CVH_A_LOOP];

   assign pageLen  = {4'h0, wordB_reg[2:0], 2'h0} * 9'h008 + `CVH_PAGE_STEP;
   assign pageDone = pageByte & (pageCnt_reg + 9'h001 >= pageLen);

   // Page counter wraps at the programmed length.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         pageCnt_reg <= 9'h000;
      else if (pageDone)
         pageCnt_reg <= 9'h000;
      else if (pageByte)
         pageCnt_reg <= pageCnt_reg + 9'h001;
   end

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         level_reg <= `CVH_WORD_RST;
      else if (pageDone)
         level_reg <= {levelC, levelAB};
   end

   assign bothOvr   = flag_reg[`CVH_F_ENCOVR] & flag_reg[`CVH_F_DECOVR];
   assign pathReset = bothOvr & (wrDec | rdEnc);

   // buffer frozen while overspilled
   // The byte that causes the overspill is dropped as well, so the buffer
   // keeps exactly what it held when the ready flag was raised.
   assign encArrive = encByteDone & ~flag_reg[`CVH_F_ENCOVR];
   assign encMiss   = encArrive & flag_reg[`CVH_F_ENCRDY] & ~rdEnc;
   assign encPush   = encArrive & ~encMiss & encInReady;

   // Encode buffer: the encoder fills it, host reads drain it.
   cvh_buf2 uEncBuf
   (
      .core_clk (core_clk),
      .resetn   (resetn),
      .flush    (pathReset),
      .inValid  (encPush),
      .inReady  (encInReady),
      .inData   (encByte),
      .outValid (encValid),
      .outReady (rdEnc),
      .outData  (encHead)
   );

   assign decRefill = decByteDone;
   assign decPop    = decRefill & ~flag_reg[`CVH_F_DECOVR] & decValid;

   // Decode buffer: host writes fill it, the decode register drains it.
   cvh_buf2 uDecBuf
   (
      .core_clk (core_clk),
      .resetn   (resetn),
      .flush    (pathReset),
      .inValid  (wrDec),
      .inReady  (),
      .inData   (dinS),
      .outValid (decValid),
      .outReady (decPop),
      .outData  (decHead)
   );

   // Decode register feed: buffer byte, or idle pattern when overspilled
   // without loopback; with loopback the encoder feeds the register.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         decByte <= `CVH_IDLE_PAT;
         decLoad <= 1'b0;
      end
      else
      begin
         decLoad <= decRefill;
         if (decPop)
            decByte <= decHead;
         else if (decRefill && !loopBack)
            decByte <= `CVH_IDLE_PAT;
         else if (decRefill)
            decByte <= encByte;
      end
   end

   // Flags: a hardware set in the same cycle as a clear wins.
   // missed service becomes overspill
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         flag_reg <= 6'h00;
      else
      begin
         if (rdEnc || flag_reg[`CVH_F_ENCOVR] || pathReset)
            flag_reg[`CVH_F_ENCRDY] <= 1'b0;
         if (encPush)
            flag_reg[`CVH_F_ENCRDY] <= 1'b1;
         // encode overspill clear
         // The ready flag is already down once overspilled, so any read
         // of the encode buffer is the service that ends it.
         if (rdEnc || pathReset)
            flag_reg[`CVH_F_ENCOVR] <= 1'b0;
         if (encMiss)
         begin
            flag_reg[`CVH_F_ENCOVR] <= 1'b1;
            flag_reg[`CVH_F_ENCRDY] <= 1'b0;
         end
         if (wrDec || flag_reg[`CVH_F_DECOVR] || pathReset)
            flag_reg[`CVH_F_DECRDY] <= 1'b0;
         if (decPop)
            flag_reg[`CVH_F_DECRDY] <= 1'b1;
         // decode overspill clear
         // Likewise any write of the decode buffer ends the overspill.
         if (wrDec || pathReset)
            flag_reg[`CVH_F_DECOVR] <= 1'b0;
         if (decRefill && !decValid && !flag_reg[`CVH_F_DECOVR])
         begin
            flag_reg[`CVH_F_DECOVR] <= 1'b1;
            flag_reg[`CVH_F_DECRDY] <= 1'b0;
         end
         if (rdLevel || flag_reg[`CVH_F_PGOVR])
            flag_reg[`CVH_F_PGRDY] <= 1'b0;
         if (rdLevel || wrB)
            flag_reg[`CVH_F_PGOVR] <= 1'b0;
         if (pageDone && !(flag_reg[`CVH_F_PGRDY] && !rdLevel))
            flag_reg[`CVH_F_PGRDY] <= 1'b1;
         if (pageDone && flag_reg[`CVH_F_PGRDY] && !rdLevel)
         begin
            flag_reg[`CVH_F_PGOVR] <= 1'b1;
            flag_reg[`CVH_F_PGRDY] <= 1'b0;
         end
      end
   end

   // Read data registered from the synchronised selection.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         dataOut <= 8'h00;
      else if (sel == `CVH_SEL_A)
         dataOut <= {2'h0, flag_reg};
      else if (sel == `CVH_SEL_B)
         dataOut <= level_reg;
      else if (sel == `CVH_SEL_DATA)
         dataOut <= encHead;
      else
         dataOut <= 8'h00;
   end

   assign irqNOut = 1'b0;
   assign irqNOe  = flag_reg[`CVH_F_ENCRDY] | flag_reg[`CVH_F_DECRDY]
                  | flag_reg[`CVH_F_PGRDY];
endmodule
`default_nettype wire

// File: pkg/cvh_map.vh
// Register selection codes, field positions and reset values of the codec port.
`ifndef CVH_MAP_VH
`define CVH_MAP_VH
// Select codes {addr1, addr0}.
`define CVH_SEL_A      2'h0
`define CVH_SEL_B      2'h1
`define CVH_SEL_DATA   2'h2
// Instruction word A fields.
`define CVH_A_IDLE     0
`define CVH_A_LOOP     1
// Instruction word B fields.
`define CVH_B_OUTA     4
`define CVH_B_OUTB     5
`define CVH_B_PSAVE    6
`define CVH_B_SENS     7
// Flag word fields.
`define CVH_F_ENCRDY   0
`define CVH_F_DECRDY   1
`define CVH_F_PGRDY    2
`define CVH_F_ENCOVR   3
`define CVH_F_DECOVR   4
`define CVH_F_PGOVR    5
// Reset values.
`define CVH_WORD_RST   8'h00
`define CVH_IDLE_PAT   8'hAA
// Page length step in bytes.
`define CVH_PAGE_STEP  9'h020
`endif

// File: verification/cvh_host_model.sv
// Host processor model that drives the codec's byte-wide port.
`timescale 1ns/1ns
`default_nettype none
module cvh_host_model
(
   input  wire logic       core_clk,     // System clock.
   output var  logic       csN,          // Chip select, low.
   output var  logic       addr0,        // Address line 0.
   output var  logic       addr1,        // Address line 1.
   output var  logic       readNotWrite, // High reads.
   output wire logic [7:0] dataIn,       // Bus level at device.
   input  wire logic [7:0] dataOut,      // Device read data.
   input  wire logic       dataOe,       // Device drives bus.
   input  wire logic       irqNOut,      // Request pin level.
   input  wire logic       irqNOe,       // Request pin enable.
   output wire logic       irqN          // Request wire level.
);
   logic [7:0] hostData; // Byte the host drives.
   logic       hostOe;   // Host drives the bus.
   // pulled up wire
   // The pull-up holds the shared request wire high when nobody pulls.
   assign irqN = irqNOe ? irqNOut : 1'b1;
   // A bus nobody drives shows the inverse, so stale data cannot pass.
   assign dataIn = hostOe ? hostData : (dataOe ? dataOut : ~hostData);
   // The port starts deselected.
   initial
   begin
      {csN, addr1, addr0, readNotWrite, hostOe} = 5'h10;
      hostData = 8'h00;
   end
   // register access
   // One access per select period; pins move on the falling edge and
   // stay put until the device has synchronised and acted.
   task automatic access(input logic [1:0] sel, input logic rd,
                         input logic [7:0] wdata, output logic [7:0] rdata);
      @(negedge core_clk);
      {addr1, addr0} = sel;
      readNotWrite = rd;
      hostData = wdata;
      hostOe = !rd;
      csN = 1'b0;
      repeat (3) @(negedge core_clk);
      rdata = dataOut;
      @(negedge core_clk);
      csN = 1'b1;
      hostOe = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// File: verification/cvh_host_port_asserts.sv
// Concurrent checks on the codec host port pins.
`timescale 1ns/1ns
`default_nettype none
module cvh_host_port_asserts
(
   input wire logic core_clk,     // Clock.
   input wire logic resetn,       // Reset, low.
   input wire logic csN,          // Select, low.
   input wire logic addr0,        // Address 0.
   input wire logic addr1,        // Address 1.
   input wire logic readNotWrite, // High reads.
   input wire logic dataOe,       // Bus enable.
   input wire logic encByteDone,  // Encode byte.
   input wire logic decByteDone,  // Decode empty.
   input wire logic decLoad,      // Decode load.
   input wire logic pageByte,     // Page step.
   input wire logic outADirect,   // Switch A.
   input wire logic outBDecoder,  // Switch B.
   input wire logic powerSave,    // Power-save.
   input wire logic highSense,    // Range.
   input wire logic irqNOut,      // Request level.
   input wire logic irqNOe        // Request enable.
);
   // One clock domain, so clock and reset are set once here.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   chk_irq_low: assert property (irqNOut == 1'b0)
      else $error("request pin driven high");
   chk_dec_load: assert property (decByteDone |=> decLoad)
      else $error("decode register not reloaded");
   chk_load_cause: assert property (decLoad |-> $past(decByteDone))
      else $error("decode load without request");
   chk_enc_irq: assert property (encByteDone && !irqNOe |=> irqNOe)
      else $error("encoded byte raised no request");
   // The pins pass two flip-flops, so the bus enable lags select by two.
   chk_oe_cause: assert property (dataOe |-> !$past(csN, 2) &&
      $past(readNotWrite, 2) && $past({addr1, addr0}, 2) != 2'h3)
      else $error("bus driven without a read");
   chk_oe_idle: assert property (csN [*3] |-> !dataOe)
      else $error("bus driven while deselected");
   chk_word_write: assert property (
      !$stable({highSense, powerSave, outBDecoder, outADirect}) |->
      !$past(csN, 3) && !$past(readNotWrite, 3) &&
      $past({addr1, addr0}, 3) == 2'h1)
      else $error("switch outputs changed without a write");
   chk_irq_cause: assert property ($rose(irqNOe) |->
      $past(encByteDone || decByteDone || pageByte) ||
      $past(decByteDone || pageByte, 2) || $past(decByteDone, 3))
      else $error("request raised without an event");
endmodule
bind cvh_host_port cvh_host_port_asserts i_chk
(
   .core_clk(core_clk), .resetn(resetn), .csN(csN), .addr0(addr0),
   .addr1(addr1), .readNotWrite(readNotWrite), .dataOe(dataOe),
   .encByteDone(encByteDone), .decByteDone(decByteDone),
   .decLoad(decLoad), .pageByte(pageByte), .outADirect(outADirect),
   .outBDecoder(outBDecoder), .powerSave(powerSave),
   .highSense(highSense), .irqNOut(irqNOut), .irqNOe(irqNOe)
);
`default_nettype wire

// File: verification/cvh_host_port_tb_top.sv
// Self-checking bench for the codec host port.
`timescale 1ns/1ns
`default_nettype none
module cvh_host_port_tb_top;
   logic       core_clk, resetn, csN, addr0, addr1, readNotWrite, dataOe;
   logic       encByteDone, decByteDone, decLoad, pageByte, irqN;
   logic       outADirect, outBDecoder, powerSave, highSense, encIdle;
   logic       loopBack, irqNOut, irqNOe;
   logic [7:0] dataIn, dataOut, encByte, decByte, rdv;
   logic [3:0] levelAB, levelC;
   int         err_count = 0; // Mismatches seen.
   int         checked = 0;   // Comparisons made.
   // Rows: select, written byte, expected switch outputs.
   logic [15:0] rows [8] = '{{2'h1, 8'h10, 6'h04}, {2'h1, 8'h20, 6'h08},
      {2'h1, 8'h40, 6'h10}, {2'h1, 8'h80, 6'h20}, {2'h0, 8'h02, 6'h22},
      {2'h0, 8'h01, 6'h21}, {2'h1, 8'h00, 6'h01}, {2'h0, 8'h00, 6'h00}};
   wire logic [7:0] sw = {2'h0, highSense, powerSave, outBDecoder,
                          outADirect, loopBack, encIdle}; // Switch view.
   cvh_host_port i_dut (.core_clk(core_clk), .resetn(resetn), .csN(csN),
      .addr0(addr0), .addr1(addr1), .readNotWrite(readNotWrite),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .encByteDone(encByteDone), .encByte(encByte),
      .decByteDone(decByteDone), .decByte(decByte), .decLoad(decLoad),
      .pageByte(pageByte), .levelAB(levelAB), .levelC(levelC),
      .outADirect(outADirect), .outBDecoder(outBDecoder),
      .powerSave(powerSave), .highSense(highSense), .encIdle(encIdle),
      .loopBack(loopBack), .irqNOut(irqNOut), .irqNOe(irqNOe));
   cvh_host_model i_host (.core_clk(core_clk), .csN(csN), .addr0(addr0),
      .addr1(addr1), .readNotWrite(readNotWrite), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe), .irqNOut(irqNOut),
      .irqNOe(irqNOe), .irqN(irqN));
   // Free-running 125 MHz clock.
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Compares one byte and counts the outcome.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [1:0] sel, input logic [7:0] d);
      i_host.access(sel, 1'b0, d, rdv);
   endtask
   task automatic rd(input logic [1:0] sel);
      i_host.access(sel, 1'b1, 8'h00, rdv);
   endtask
   task automatic flg(input logic [7:0] exp);
      rd(2'h0);
      check(rdv, exp);
   endtask
   task automatic irqc(input logic e);
      check({7'h00, irqN}, {7'h00, e});
   endtask
   // One-cycle core event: 0 encode, 1 decode, 2 page byte.
   task automatic ev(input int k, input logic [7:0] b);
      @(negedge core_clk);
      encByte = b;
      {encByteDone, decByteDone, pageByte} = {k == 0, k == 1, k == 2};
      @(negedge core_clk);
      {encByteDone, decByteDone, pageByte} = 3'h0;
      repeat (2) @(negedge core_clk);
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // The sequence needs about 800 cycles; this cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      $display("Error at %0t: run hung", $time);
      test_done;
   end
   // Main sequence; the mid-run reset goes last as the paths before it leave flags set.
   initial
   begin
      resetn = 1'b0;
      {encByteDone, decByteDone, pageByte} = 3'h0;
      encByte = 8'h00;
      levelAB = 4'h5;
      levelC = 4'hA;
      repeat (2) @(negedge core_clk);
      resetn = 1'b1;
      flg(8'h00);
      irqc(1'b1);
      foreach (rows[i])
      begin
         wr(rows[i][15:14], rows[i][13:6]);
         check(sw, {2'h0, rows[i][5:0]});
      end
      // The unused select must neither store nor drive.
      wr(2'h3, 8'hFF);
      rd(2'h3);
      check(rdv, 8'h00);
      flg(8'h00);
      // A page is 32 bytes with code zero.
      repeat (31) ev(2, 8'h00);
      flg(8'h00);
      ev(2, 8'h00);
      irqc(1'b0);
      flg(8'h04);
      rd(2'h1);
      check(rdv, 8'hA5);
      flg(8'h00);
      repeat (32) ev(2, 8'h00);
      levelAB = 4'h6;
      repeat (32) ev(2, 8'h00);
      flg(8'h20);
      wr(2'h1, 8'h00);
      flg(8'h00);
      rd(2'h1);
      check(rdv, 8'hA6);
      // Encode path, then a missed read.
      ev(0, 8'h3C);
      irqc(1'b0);
      flg(8'h01);
      rd(2'h2);
      check(rdv, 8'h3C);
      flg(8'h00);
      ev(0, 8'h11);
      ev(0, 8'h22);
      flg(8'h08);
      irqc(1'b1);
      rd(2'h2);
      check(rdv, 8'h11);
      flg(8'h00);
      // Decode path: fill the buffer past full, then drain it dry.
      wr(2'h2, 8'h5A);
      ev(1, 8'h00);
      check(decByte, 8'h5A);
      flg(8'h02);
      irqc(1'b0);
      wr(2'h2, 8'h81);
      wr(2'h2, 8'h82);
      wr(2'h2, 8'h83);
      flg(8'h00);
      ev(1, 8'h00);
      check(decByte, 8'h81);
      ev(1, 8'h00);
      check(decByte, 8'h82);
      flg(8'h02);
      ev(1, 8'h00);
      check(decByte, 8'hAA);
      flg(8'h10);
      wr(2'h2, 8'h77);
      flg(8'h00);
      ev(1, 8'h00);
      check(decByte, 8'h77);
      // Both paths overspill with loopback on; one access clears both.
      wr(2'h0, 8'h02);
      ev(0, 8'h31);
      ev(0, 8'h32);
      ev(1, 8'h4D);
      check(decByte, 8'h4D);
      flg(8'h18);
      rd(2'h2);
      check(rdv, 8'h31);
      flg(8'h00);
      ev(0, 8'h44);
      flg(8'h01);
      rd(2'h2);
      check(rdv, 8'h44);
      ev(0, 8'h55);
      // A second reset in mid-run returns every register to its start.
      @(negedge core_clk);
      resetn = 1'b0;
      repeat (2) @(negedge core_clk);
      resetn = 1'b1;
      check(sw, 8'h00);
      check(decByte, 8'hAA);
      flg(8'h00);
      irqc(1'b1);
      test_done;
   end
endmodule
`default_nettype wire
